// ### include/wtr_pkg.sv
package wtr_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int              ADDR_W        = 8;
  localparam logic [7:0]      CTRL_OFFSET   = 8'h00;
  localparam logic [7:0]      DATA_OFFSET   = 8'h04;
  localparam logic [7:0]      SHAPE_OFFSET  = 8'h08;

  // ----------------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------------
  localparam int              DONE_BIT      = 6;
  localparam int              DIR_BIT       = 5;
  localparam int              INDEX_W       = 5;
  localparam int              SAMPLE_W      = 7;
  localparam int              SHAPE_W       = 4;
  localparam int              SHAPE_MSB     = 3;
  localparam int              RAM_DEPTH     = 20;
  localparam logic [4:0]      LAST_ENTRY    = 5'h13;

  // ----------------------------------------------------------------------
  // reset values and responses
  // ----------------------------------------------------------------------
  localparam logic [4:0]      INDEX_RESET   = 5'h00;
  localparam logic [6:0]      SAMPLE_RESET  = 7'h00;
  localparam logic [3:0]      SHAPE_RESET   = 4'h0;
  localparam logic [1:0]      RESP_OKAY     = 2'h0;
  localparam logic [1:0]      RESP_SLVERR   = 2'h2;

endpackage

// ### verilog/wtr_template_ram.sv
`timescale 1ns/1ns
`default_nettype none
module wtr_template_ram
  import wtr_pkg::*;
(
  // clocking
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                clkEn,
  // access
  input  wire logic                wrEn,
  input  wire logic [INDEX_W-1:0]  index,
  input  wire logic [SAMPLE_W-1:0] wrValue,
  output logic      [SAMPLE_W-1:0] rdValue
);

  logic [INDEX_W-1:0]  entrySel;
  logic [SAMPLE_W-1:0] mem_reg  [RAM_DEPTH];
  logic [SAMPLE_W-1:0] mem_next [RAM_DEPTH];

  // --------------------------------------------------------------------
  // index decode
  // --------------------------------------------------------------------
  always_comb begin
    entrySel = (index > LAST_ENTRY) ? LAST_ENTRY : index;
  end

  // --------------------------------------------------------------------
  // entries
  // --------------------------------------------------------------------
  for (genvar i = 0; i < RAM_DEPTH; i++) begin : gEntry
    always_comb begin
      mem_next[i] = (wrEn && entrySel == INDEX_W'(i)) ? wrValue : mem_reg[i];
    end
    always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
        mem_reg[i] <= SAMPLE_RESET;
      end else if (clkEn) begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  assign rdValue = mem_reg[entrySel];

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  addr_low_a: assert property (@(posedge clk) disable iff (sys_rst)
    index <= 5'h12 |-> entrySel == index)
    else $error("low index not mapped directly");

  addr_sat_a: assert property (@(posedge clk) disable iff (sys_rst)
    index > 5'h12 |-> entrySel == 5'h13)
    else $error("high index not saturated to last entry");

  store_entry_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrEn && clkEn |=> mem_reg[$past(entrySel)] == $past(wrValue))
    else $error("sample not stored in selected entry");

endmodule
`default_nettype wire

// ### verilog/wtr_waveform_port.sv
`timescale 1ns/1ns
`default_nettype none
module wtr_waveform_port
  import wtr_pkg::*;
(
  // clocking
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              clkEn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // transmitter side
  output logic                   templateCommit,
  output logic [SHAPE_W-1:0]     pulseShapeSelect
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  logic               awHeld_reg,   awHeld_next;
  logic               wHeld_reg,    wHeld_next;
  logic [ADDR_W-1:0]  awAddr_reg,   awAddr_next;
  logic [31:0]        wData_reg,    wData_next;
  logic               wStrb0_reg,   wStrb0_next;
  logic               awReady_reg,  awReady_next;
  logic               wReady_reg,   wReady_next;
  logic               bValid_reg,   bValid_next;
  logic [1:0]         bResp_reg,    bResp_next;
  logic               arReady_reg,  arReady_next;
  logic               rValid_reg,   rValid_next;
  logic [31:0]        rData_reg,    rData_next;
  logic [1:0]         rResp_reg,    rResp_next;
  logic               done_reg,     done_next;
  logic               dir_reg,      dir_next;
  logic [INDEX_W-1:0] index_reg,    index_next;
  logic [SAMPLE_W-1:0] sample_reg,  sample_next;
  logic [SHAPE_W-1:0] shape_reg,    shape_next;
  logic               wrFire;
  logic               rdFire;
  logic               ramWrEn;
  logic [SAMPLE_W-1:0] ramRdValue;
  logic               templateOn;

  assign templateOn = shape_reg[SHAPE_MSB];

  // --------------------------------------------------------------------
  // template ram
  // --------------------------------------------------------------------
  wtr_template_ram uRam (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clkEn   (clkEn),
    .wrEn    (ramWrEn),
    .index   (index_reg),
    .wrValue (sample_next),
    .rdValue (ramRdValue)
  );

  // --------------------------------------------------------------------
  // write channel and registers
  // --------------------------------------------------------------------
  always_comb begin
    awHeld_next = awHeld_reg;
    wHeld_next  = wHeld_reg;
    awAddr_next = awAddr_reg;
    wData_next  = wData_reg;
    wStrb0_next = wStrb0_reg;
    bValid_next = bValid_reg;
    bResp_next  = bResp_reg;
    done_next   = done_reg;
    dir_next    = dir_reg;
    index_next  = index_reg;
    sample_next = sample_reg;
    shape_next  = shape_reg;
    ramWrEn     = 1'b0;
    wrFire      = awHeld_reg && wHeld_reg && !bValid_reg;
    if (s_axi_awvalid && awReady_reg) begin
      awHeld_next = 1'b1;
      awAddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wReady_reg) begin
      wHeld_next  = 1'b1;
      wData_next  = s_axi_wdata;
      wStrb0_next = s_axi_wstrb[0];
    end
    if (bValid_reg && s_axi_bready) begin
      bValid_next = 1'b0;
    end
    if (wrFire) begin
      awHeld_next = 1'b0;
      wHeld_next  = 1'b0;
      bValid_next = 1'b1;
      bResp_next  = RESP_OKAY;
      if (awAddr_reg == CTRL_OFFSET) begin
        if (wStrb0_reg) begin
          done_next  = wData_reg[DONE_BIT];
          dir_next   = wData_reg[DIR_BIT];
          index_next = wData_reg[INDEX_W-1:0];
        end
      end else if (awAddr_reg == DATA_OFFSET) begin
        if (wStrb0_reg) begin
          sample_next = wData_reg[SAMPLE_W-1:0];
          ramWrEn     = templateOn && !dir_reg;
        end
      end else if (awAddr_reg == SHAPE_OFFSET) begin
        if (wStrb0_reg) begin
          shape_next = wData_reg[SHAPE_W-1:0];
        end
      end else begin
        bResp_next = RESP_SLVERR;
      end
    end
    awReady_next = !awHeld_next;
    wReady_next  = !wHeld_next;
  end

  // --------------------------------------------------------------------
  // read channel
  // --------------------------------------------------------------------
  always_comb begin
    rValid_next = rValid_reg;
    rData_next  = rData_reg;
    rResp_next  = rResp_reg;
    rdFire      = s_axi_arvalid && arReady_reg;
    if (rValid_reg && s_axi_rready) begin
      rValid_next = 1'b0;
    end
    if (rdFire) begin
      rValid_next = 1'b1;
      rResp_next  = RESP_OKAY;
      rData_next  = '0;
      if (s_axi_araddr == CTRL_OFFSET) begin
        rData_next[DONE_BIT]      = done_reg;
        rData_next[DIR_BIT]       = dir_reg;
        rData_next[INDEX_W-1:0]   = index_reg;
      end else if (s_axi_araddr == DATA_OFFSET) begin
        if (templateOn && dir_reg) begin
          rData_next[SAMPLE_W-1:0] = ramRdValue;
        end else begin
          rData_next[SAMPLE_W-1:0] = sample_reg;
        end
      end else if (s_axi_araddr == SHAPE_OFFSET) begin
        rData_next[SHAPE_W-1:0] = shape_reg;
      end else begin
        rResp_next = RESP_SLVERR;
      end
    end
    arReady_next = !rValid_next;
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      awHeld_reg  <= 1'b0;
      wHeld_reg   <= 1'b0;
      awAddr_reg  <= '0;
      wData_reg   <= '0;
      wStrb0_reg  <= 1'b0;
      awReady_reg <= 1'b0;
      wReady_reg  <= 1'b0;
      bValid_reg  <= 1'b0;
      bResp_reg   <= RESP_OKAY;
      arReady_reg <= 1'b0;
      rValid_reg  <= 1'b0;
      rData_reg   <= '0;
      rResp_reg   <= RESP_OKAY;
      done_reg    <= 1'b0;
      dir_reg     <= 1'b0;
      index_reg   <= INDEX_RESET;
      sample_reg  <= SAMPLE_RESET;
      shape_reg   <= SHAPE_RESET;
    end else if (clkEn) begin
      awHeld_reg  <= awHeld_next;
      wHeld_reg   <= wHeld_next;
      awAddr_reg  <= awAddr_next;
      wData_reg   <= wData_next;
      wStrb0_reg  <= wStrb0_next;
      awReady_reg <= awReady_next;
      wReady_reg  <= wReady_next;
      bValid_reg  <= bValid_next;
      bResp_reg   <= bResp_next;
      arReady_reg <= arReady_next;
      rValid_reg  <= rValid_next;
      rData_reg   <= rData_next;
      rResp_reg   <= rResp_next;
      done_reg    <= done_next;
      dir_reg     <= dir_next;
      index_reg   <= index_next;
      sample_reg  <= sample_next;
      shape_reg   <= shape_next;
    end
  end

  assign s_axi_awready    = awReady_reg;
  assign s_axi_wready     = wReady_reg;
  assign s_axi_bvalid     = bValid_reg;
  assign s_axi_bresp      = bResp_reg;
  assign s_axi_arready    = arReady_reg;
  assign s_axi_rvalid     = rValid_reg;
  assign s_axi_rdata      = rData_reg;
  assign s_axi_rresp      = rResp_reg;
  assign templateCommit   = done_reg;
  assign pulseShapeSelect = shape_reg;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  sequence dataWriteSeq;
    wrFire && clkEn && awAddr_reg == DATA_OFFSET && wStrb0_reg;
  endsequence

  sequence dataReadSeq;
    rdFire && clkEn && s_axi_araddr == DATA_OFFSET;
  endsequence

  ram_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    ramWrEn |-> templateOn)
    else $error("ram written while template mode off");

  write_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
    dataWriteSeq and (templateOn && !dir_reg) |-> ramWrEn)
    else $error("write direction did not write ram");

  read_dir_a: assert property (@(posedge clk) disable iff (sys_rst)
    dir_reg |-> !ramWrEn)
    else $error("ram written in read direction");

  reset_index_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> index_reg == 5'h00 && !dir_reg)
    else $error("index not zero after reset");

  data_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !(wrFire && clkEn && awAddr_reg == DATA_OFFSET) |=> $stable(sample_reg))
    else $error("sample register changed without write");

  readback_a: assert property (@(posedge clk) disable iff (sys_rst)
    dataReadSeq and (templateOn && dir_reg) |=> s_axi_rvalid
      && s_axi_rdata[6:0] == $past(ramRdValue) && s_axi_rdata[31:7] == '0)
    else $error("read back is not the selected entry");

  commit_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
    $past(sys_rst) |-> !templateCommit)
    else $error("commit bit not clear after reset");

  write_resp_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrFire && clkEn |=> s_axi_bvalid)
    else $error("write response missing");

  resp_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped before taken");

endmodule
`default_nettype wire

// ### tb/waveform_template_ram_port_test.sv
`timescale 1ns/1ns
`default_nettype none
module waveform_template_ram_port_test;
  import wtr_pkg::*;

  // ----------------------------------------------------------------------
  // bench signals
  // ----------------------------------------------------------------------
  logic              clk;
  logic              sys_rst;
  logic              clkEn;
  logic [ADDR_W-1:0] awAddr;
  logic              awValid;
  logic              awReady;
  logic [31:0]       wData;
  logic [3:0]        wStrb;
  logic              wValid;
  logic              wReady;
  logic [1:0]        bResp;
  logic              bValid;
  logic              bReady;
  logic [ADDR_W-1:0] arAddr;
  logic              arValid;
  logic              arReady;
  logic [31:0]       rData;
  logic [1:0]        rResp;
  logic              rValid;
  logic              rReady;
  logic              templateCommit;
  logic [SHAPE_W-1:0] pulseShapeSelect;
  int                miscompares = 0;
  int                num_checks  = 0;

  wtr_waveform_port i_dut (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .clkEn            (clkEn),
    .s_axi_awaddr     (awAddr),
    .s_axi_awvalid    (awValid),
    .s_axi_awready    (awReady),
    .s_axi_wdata      (wData),
    .s_axi_wstrb      (wStrb),
    .s_axi_wvalid     (wValid),
    .s_axi_wready     (wReady),
    .s_axi_bresp      (bResp),
    .s_axi_bvalid     (bValid),
    .s_axi_bready     (bReady),
    .s_axi_araddr     (arAddr),
    .s_axi_arvalid    (arValid),
    .s_axi_arready    (arReady),
    .s_axi_rdata      (rData),
    .s_axi_rresp      (rResp),
    .s_axi_rvalid     (rValid),
    .s_axi_rready     (rReady),
    .templateCommit   (templateCommit),
    .pulseShapeSelect (pulseShapeSelect)
  );

  // ----------------------------------------------------------------------
  // verdict and compare
  // ----------------------------------------------------------------------
  task automatic close_out;
    if (miscompares == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------------
  task automatic wr_finish(input logic [1:0] er);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (awValid && awReady) awValid <= 1'h0;
      if (wValid && wReady) wValid <= 1'h0;
    end while (bValid !== 1'h1 && n < 64);
    if (n >= 64) begin
      miscompares++;
      close_out();
    end
    check("bresp", {30'h0, er}, {30'h0, bResp});
    bReady <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    @(posedge clk);
    awAddr  <= a;
    wData   <= d;
    wStrb   <= s;
    awValid <= 1'h1;
    wValid  <= 1'h1;
    bReady  <= 1'h1;
    wr_finish(er);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge clk);
    arAddr  <= a;
    arValid <= 1'h1;
    rReady  <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (arValid && arReady) arValid <= 1'h0;
    end while (rValid !== 1'h1 && n < 64);
    if (n >= 64) begin
      miscompares++;
      close_out();
    end
    check("rdata", ed, rData);
    check("rresp", {30'h0, er}, {30'h0, rResp});
    rReady <= 1'h0;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic reset_values;
    rd(CTRL_OFFSET, 32'h0, RESP_OKAY);
    rd(DATA_OFFSET, 32'h0, RESP_OKAY);
    check("templateCommit", 32'h0, {31'h0, templateCommit});
    rd(8'h0C, 32'h0, RESP_SLVERR);
    wr(8'h0C, 32'h7F, 4'h1, RESP_SLVERR);
  endtask

  task automatic gated_access;
    wr(SHAPE_OFFSET, 32'h7, 4'h1, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h03, 4'h1, RESP_OKAY);
    wr(DATA_OFFSET, 32'h55, 4'h1, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h23, 4'h1, RESP_OKAY);
    rd(DATA_OFFSET, 32'h55, RESP_OKAY);
    wr(SHAPE_OFFSET, 32'h8, 4'h1, RESP_OKAY);
    check("pulseShapeSelect", 32'h8, {28'h0, pulseShapeSelect});
    rd(DATA_OFFSET, 32'h0, RESP_OKAY);
  endtask

  task automatic sweep_entries;
    logic [31:0] exp;
    for (int i = 0; i < 32; i++) begin
      wr(CTRL_OFFSET, 32'(i), 4'h1, RESP_OKAY);
      wr(DATA_OFFSET, 32'h40 + 32'(i), 4'h1, RESP_OKAY);
    end
    for (int i = 0; i < 32; i++) begin
      exp = (i < 19) ? 32'h40 + 32'(i) : 32'h5F;
      wr(CTRL_OFFSET, 32'h20 | 32'(i), 4'h1, RESP_OKAY);
      rd(CTRL_OFFSET, 32'h20 | 32'(i), RESP_OKAY);
      rd(DATA_OFFSET, exp, RESP_OKAY);
    end
  endtask

  task automatic data_holds;
    wr(CTRL_OFFSET, 32'h00, 4'h1, RESP_OKAY);
    wr(DATA_OFFSET, 32'h11, 4'h0, RESP_OKAY);
    rd(DATA_OFFSET, 32'h5F, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h33, 4'h1, RESP_OKAY);
    rd(DATA_OFFSET, 32'h5F, RESP_OKAY);
  endtask

  task automatic commit_bit;
    wr(CTRL_OFFSET, 32'hFF, 4'h1, RESP_OKAY);
    check("templateCommit", 32'h1, {31'h0, templateCommit});
    rd(CTRL_OFFSET, 32'h7F, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h00, 4'h1, RESP_OKAY);
    check("templateCommit", 32'h0, {31'h0, templateCommit});
  endtask

  task automatic freeze_state;
    @(posedge clk);
    clkEn   <= 1'h0;
    awAddr  <= CTRL_OFFSET;
    wData   <= 32'h45;
    wStrb   <= 4'h1;
    awValid <= 1'h1;
    wValid  <= 1'h1;
    bReady  <= 1'h1;
    repeat (6) @(posedge clk);
    check("bValid", 32'h0, {31'h0, bValid});
    check("templateCommit", 32'h0, {31'h0, templateCommit});
    clkEn   <= 1'h1;
    wr_finish(RESP_OKAY);
    check("templateCommit", 32'h1, {31'h0, templateCommit});
    rd(CTRL_OFFSET, 32'h45, RESP_OKAY);
  endtask

  task automatic mid_reset;
    @(posedge clk);
    sys_rst <= 1'h1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    check("pulseShapeSelect", 32'h0, {28'h0, pulseShapeSelect});
    check("templateCommit", 32'h0, {31'h0, templateCommit});
    rd(CTRL_OFFSET, 32'h0, RESP_OKAY);
    rd(DATA_OFFSET, 32'h0, RESP_OKAY);
    wr(SHAPE_OFFSET, 32'h8, 4'h1, RESP_OKAY);
    wr(CTRL_OFFSET, 32'h33, 4'h1, RESP_OKAY);
    rd(DATA_OFFSET, 32'h0, RESP_OKAY);
  endtask

  // ----------------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  initial begin
    sys_rst = 1'h1;
    clkEn   = 1'h1;
    awAddr  = '0;
    awValid = 1'h0;
    wData   = '0;
    wStrb   = 4'h0;
    wValid  = 1'h0;
    bReady  = 1'h0;
    arAddr  = '0;
    arValid = 1'h0;
    rReady  = 1'h0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    reset_values();
    gated_access();
    sweep_entries();
    data_holds();
    commit_bit();
    freeze_state();
    mid_reset();
    close_out();
  end

endmodule
`default_nettype wire
